// file: common/gpio_port_pkg.sv
package gpio_port_pkg;

  // ****************************************
  // Port geometry.
  // ****************************************
  localparam int LINES = 8;
  localparam int ADDR_W = 8;

  // ****************************************
  // Register offsets, byte addresses.
  // ****************************************
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_BITOP = 8'h08;
  localparam logic [7:0] OFS_INV_READ = 8'h0C;
  localparam logic [7:0] OFS_PULL = 8'h10;
  localparam logic [7:0] OFS_WAKE = 8'h14;
  localparam logic [7:0] OFS_TRIG = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_PDOWN = 8'h24;

  // ****************************************
  // Field positions.
  // ****************************************
  localparam int BITOP_IDX_LSB = 0;
  localparam int BITOP_OP_LSB = 4;
  localparam int TRIG0_LSB = 0;
  localparam int TRIG1_LSB = 2;
  localparam int ST_IRQ0 = 0;
  localparam int ST_IRQ1 = 1;
  localparam int ST_WAKE = 2;
  localparam int ST_W = 3;
  localparam int TIMER_LINE = 2;

  // ****************************************
  // Values after reset.
  // ****************************************
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [3:0] RST_TRIG = 4'h0;
  localparam logic [2:0] RST_STATUS = 3'h0;
  localparam logic [2:0] RST_MASK = 3'h0;

  // ****************************************
  // Encodings.
  // ****************************************
  typedef enum logic [1:0] {
    TRIG_OFF = 2'h0,
    TRIG_RISE = 2'h1,
    TRIG_FALL = 2'h2,
    TRIG_BOTH = 2'h3
  } trig_type;

  localparam logic [1:0] BITOP_SET = 2'h1;
  localparam logic [1:0] BITOP_CLR = 2'h2;
  localparam logic [1:0] BITOP_INV = 2'h3;

endpackage

// file: logic/pin_sync.sv
module pin_sync (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic [7:0] PAD_IN,
  output logic [7:0] SYNC_OUT
);

  typedef struct packed {
    logic [7:0] meta;
    logic [7:0] sync;
  } sync_state_type;

  sync_state_type state_q;
  sync_state_type state_d;

  // Only the second stage is visible; the first settles metastability.
  always_comb begin
    state_d = state_q;
    if (CE_IN) begin
      state_d.meta = PAD_IN;
      state_d.sync = state_q.meta;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign SYNC_OUT = state_q.sync;

endmodule

// file: logic/edge_trigger.sv
module edge_trigger (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic SIG_IN,
  input wire gpio_port_pkg::trig_type MODE_IN,
  output logic HIT_OUT
);

  typedef struct packed {
    logic prev;
    logic [2:0] warm;
  } trig_state_type;

  trig_state_type state_q;
  trig_state_type state_d;
  logic rise;
  logic fall;

  // The detector stays blind until the synchroniser and the previous sample hold real levels.
  // Otherwise a pulled-high pin would fake a rising edge just after reset.
  assign rise = state_q.warm[2] && SIG_IN && !state_q.prev;
  assign fall = state_q.warm[2] && !SIG_IN && state_q.prev;

  always_comb begin
    state_d = state_q;
    if (CE_IN) begin
      state_d.prev = SIG_IN;
      state_d.warm = {state_q.warm[1:0], 1'b1};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    unique case (MODE_IN)
      gpio_port_pkg::TRIG_OFF: HIT_OUT = 1'b0;
      gpio_port_pkg::TRIG_RISE: HIT_OUT = CE_IN && rise;
      gpio_port_pkg::TRIG_FALL: HIT_OUT = CE_IN && fall;
      gpio_port_pkg::TRIG_BOTH: HIT_OUT = CE_IN && (rise || fall);
    endcase
  end

  trig_rise_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    CE_IN && $past(CE_IN) && state_q.warm[2] && MODE_IN == gpio_port_pkg::TRIG_RISE &&
      $rose(SIG_IN) |-> HIT_OUT)
    else $error("Rising edge missed.");

  trig_fall_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    CE_IN && $past(CE_IN) && state_q.warm[2] && MODE_IN == gpio_port_pkg::TRIG_FALL &&
      $fell(SIG_IN) |-> HIT_OUT)
    else $error("Falling edge missed.");

  trig_off_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    MODE_IN == gpio_port_pkg::TRIG_OFF |-> !HIT_OUT)
    else $error("Disabled trigger fired.");

endmodule

// file: logic/gpio_port.sv
// Summary of operation
// - One port of eight bidirectional lines.
// - Output latches hold until rewritten.
// - Direction bit: 1 input, 0 output.
// - Read returns pad or latch per direction.
// - Reset makes every line an input.
// - Per-line pull-high enable.
// - Single bits settable and clearable alone.
// - Bit operations read, modify, write back.
// - Per-line wake-up enable from power-down.
// - Lines 0-2 feed interrupts and timer.
// - Interrupt trigger: off, rise, fall, both.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
module gpio_port (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [7:0] PAD_IN,
  output logic [7:0] PAD_OUT,
  output logic [7:0] PAD_OE_OUT,
  output logic [7:0] PULL_EN_OUT,
  output logic TIMER_EVENT_OUT,
  output logic WAKE_REQ_OUT,
  output logic POWERED_DOWN_OUT,
  output logic IRQ_OUT
);

  // ****************************************
  // State.
  // ****************************************
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pull;
    logic [7:0] wake_en;
    logic [3:0] trig;
    logic [2:0] status;
    logic [2:0] mask;
    logic pdown;
    logic wake_req;
    logic [7:0] pad_prev;
    logic [31:0] rdata;
    logic slverr;
  } port_state_type;

  port_state_type state_q;
  port_state_type state_d;

  logic [7:0] pad_s;
  logic [1:0] irq_hit;
  logic setup;
  logic access_wr;
  logic [7:0] port_rd;
  logic [7:0] wake_chg;

  // ****************************************
  // Helpers.
  // ****************************************
  function automatic logic [7:0] port_value(input logic [7:0] pad, input logic [7:0] lat,
                                            input logic [7:0] dir);
    port_value = (pad & dir) | (lat & ~dir);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    unique case (a)
      gpio_port_pkg::OFS_DATA, gpio_port_pkg::OFS_DIR, gpio_port_pkg::OFS_BITOP,
      gpio_port_pkg::OFS_INV_READ, gpio_port_pkg::OFS_PULL, gpio_port_pkg::OFS_WAKE,
      gpio_port_pkg::OFS_TRIG, gpio_port_pkg::OFS_STATUS, gpio_port_pkg::OFS_MASK,
      gpio_port_pkg::OFS_PDOWN: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Pad inputs.
  // ****************************************
  // Inputs pass a two-stage synchroniser, so the sample taken is what the pad showed two enabled cycles earlier.
  pin_sync u_sync (
    .CLK_IN(CLK_IN),
    .NRST_IN(NRST_IN),
    .CE_IN(CE_IN),
    .PAD_IN(PAD_IN),
    .SYNC_OUT(pad_s)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_irq
      edge_trigger u_trig (
        .CLK_IN(CLK_IN),
        .NRST_IN(NRST_IN),
        .CE_IN(CE_IN),
        .SIG_IN(pad_s[g]),
        .MODE_IN(gpio_port_pkg::trig_type'(state_q.trig[2*g +: 2])),
        .HIT_OUT(irq_hit[g])
      );
    end
  endgenerate

  assign TIMER_EVENT_OUT = pad_s[gpio_port_pkg::TIMER_LINE];

  // ****************************************
  // Bus decode.
  // ****************************************
  assign setup = CE_IN && PSEL_IN && !PENABLE_IN;
  assign access_wr = CE_IN && PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign port_rd = port_value(pad_s, state_q.latch, state_q.dir);
  assign wake_chg = (pad_s ^ state_q.pad_prev) & state_q.wake_en & state_q.dir;

  // ****************************************
  // Next state.
  // ****************************************
  always_comb begin
    logic [2:0] idx;
    logic [1:0] op;
    logic [7:0] rmw;
    logic [2:0] st_set;
    logic [2:0] st_clr;
    idx = PWDATA_IN[gpio_port_pkg::BITOP_IDX_LSB +: 3];
    op = PWDATA_IN[gpio_port_pkg::BITOP_OP_LSB +: 2];
    rmw = port_rd;
    st_set = '0;
    st_clr = '0;
    state_d = state_q;
    state_d.wake_req = 1'b0;
    if (CE_IN) begin
      state_d.pad_prev = pad_s;
      st_set[gpio_port_pkg::ST_IRQ0] = irq_hit[0];
      st_set[gpio_port_pkg::ST_IRQ1] = irq_hit[1];
      if (state_q.pdown && (|wake_chg)) begin
        state_d.pdown = 1'b0;
        state_d.wake_req = 1'b1;
        st_set[gpio_port_pkg::ST_WAKE] = 1'b1;
      end
      if (setup) begin
        state_d.slverr = !addr_mapped(PADDR_IN);
        unique case (PADDR_IN)
          gpio_port_pkg::OFS_DATA: state_d.rdata = {24'h000000, port_rd};
          gpio_port_pkg::OFS_DIR: state_d.rdata = {24'h000000, state_q.dir};
          gpio_port_pkg::OFS_INV_READ: state_d.rdata = {24'h000000, ~port_rd};
          gpio_port_pkg::OFS_PULL: state_d.rdata = {24'h000000, state_q.pull};
          gpio_port_pkg::OFS_WAKE: state_d.rdata = {24'h000000, state_q.wake_en};
          gpio_port_pkg::OFS_TRIG: state_d.rdata = {28'h0000000, state_q.trig};
          gpio_port_pkg::OFS_STATUS: state_d.rdata = {29'h00000000, state_q.status};
          gpio_port_pkg::OFS_MASK: state_d.rdata = {29'h00000000, state_q.mask};
          gpio_port_pkg::OFS_PDOWN: state_d.rdata = {31'h00000000, state_q.pdown};
          default: state_d.rdata = 32'h00000000;
        endcase
      end
      if (access_wr) begin
        unique case (PADDR_IN)
          gpio_port_pkg::OFS_DATA: state_d.latch = PWDATA_IN[7:0];
          gpio_port_pkg::OFS_DIR: state_d.dir = PWDATA_IN[7:0];
          gpio_port_pkg::OFS_BITOP: begin
            unique case (op)
              gpio_port_pkg::BITOP_SET: rmw[idx] = 1'b1;
              gpio_port_pkg::BITOP_CLR: rmw[idx] = 1'b0;
              gpio_port_pkg::BITOP_INV: rmw = ~rmw;
              default: rmw = port_rd;
            endcase
            if (op != 2'h0) begin
              state_d.latch = rmw;
            end
          end
          gpio_port_pkg::OFS_PULL: state_d.pull = PWDATA_IN[7:0];
          gpio_port_pkg::OFS_WAKE: state_d.wake_en = PWDATA_IN[7:0];
          gpio_port_pkg::OFS_TRIG: state_d.trig = PWDATA_IN[3:0];
          gpio_port_pkg::OFS_STATUS: st_clr = PWDATA_IN[2:0];
          gpio_port_pkg::OFS_MASK: state_d.mask = PWDATA_IN[2:0];
          gpio_port_pkg::OFS_PDOWN: begin
            if (!(state_q.pdown && (|wake_chg))) begin
              state_d.pdown = PWDATA_IN[0];
            end
          end
          default: state_d.latch = state_q.latch;
        endcase
      end
      // A new event wins over a clear written in the same cycle.
      state_d.status = (state_q.status & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      state_q.latch <= gpio_port_pkg::RST_LATCH;
      state_q.dir <= gpio_port_pkg::RST_DIR;
      state_q.pull <= gpio_port_pkg::RST_PULL;
      state_q.wake_en <= gpio_port_pkg::RST_WAKE;
      state_q.trig <= gpio_port_pkg::RST_TRIG;
      state_q.status <= gpio_port_pkg::RST_STATUS;
      state_q.mask <= gpio_port_pkg::RST_MASK;
      state_q.pdown <= 1'b0;
      state_q.wake_req <= 1'b0;
      state_q.pad_prev <= 8'h00;
      state_q.rdata <= 32'h00000000;
      state_q.slverr <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs.
  // ****************************************
  // Push-pull drive only on output lines; inputs stay released.
  assign PAD_OUT = state_q.latch;
  assign PAD_OE_OUT = ~state_q.dir;
  assign PULL_EN_OUT = state_q.pull;
  assign WAKE_REQ_OUT = state_q.wake_req;
  assign POWERED_DOWN_OUT = state_q.pdown;
  assign IRQ_OUT = |(state_q.status & state_q.mask);
  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = state_q.rdata;
  assign PSLVERR_OUT = state_q.slverr && PSEL_IN && PENABLE_IN;

  // ****************************************
  // Checks.
  // ****************************************
  sequence data_write_s;
    access_wr && PADDR_IN == gpio_port_pkg::OFS_DATA;
  endsequence

  sequence bit_set_s;
    access_wr && PADDR_IN == gpio_port_pkg::OFS_BITOP &&
      PWDATA_IN[gpio_port_pkg::BITOP_OP_LSB +: 2] == gpio_port_pkg::BITOP_SET;
  endsequence

  sequence wake_event_s;
    CE_IN && state_q.pdown && (|wake_chg);
  endsequence

  dir_reset_a: assert property (@(posedge CLK_IN)
    !NRST_IN |=> state_q.dir == gpio_port_pkg::RST_DIR && PAD_OE_OUT == 8'h00)
    else $error("Lines not inputs after reset.");

  latch_write_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    data_write_s |=> PAD_OUT == $past(PWDATA_IN[7:0]))
    else $error("Data write not latched.");

  latch_hold_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !(access_wr && (PADDR_IN == gpio_port_pkg::OFS_DATA ||
      PADDR_IN == gpio_port_pkg::OFS_BITOP)) |=> $stable(PAD_OUT))
    else $error("Latch changed without a write.");

  dir_drive_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    access_wr && PADDR_IN == gpio_port_pkg::OFS_DIR |=>
      PAD_OE_OUT == ~$past(PWDATA_IN[7:0]))
    else $error("Drive enable mismatch.");

  read_mux_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    setup && PADDR_IN == gpio_port_pkg::OFS_DATA |=>
      PRDATA_OUT[7:0] == (($past(pad_s) & $past(state_q.dir)) |
                          ($past(state_q.latch) & ~$past(state_q.dir))))
    else $error("Port read mux wrong.");

  bit_set_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    bit_set_s |=> PAD_OUT == ($past(port_rd) |
      (8'h01 << $past(PWDATA_IN[gpio_port_pkg::BITOP_IDX_LSB +: 3]))))
    else $error("Bit set disturbed the port.");

  wake_req_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    wake_event_s |=> WAKE_REQ_OUT && !POWERED_DOWN_OUT ##1 !WAKE_REQ_OUT)
    else $error("Wake request missing.");

  wake_gate_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    CE_IN && state_q.pdown && (state_q.wake_en == 8'h00) |=> !WAKE_REQ_OUT)
    else $error("Wake without enable.");

  pull_out_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    access_wr && PADDR_IN == gpio_port_pkg::OFS_PULL |=> PULL_EN_OUT == $past(PWDATA_IN[7:0]))
    else $error("Pull enable not applied.");

  irq_set_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    irq_hit[0] |=> state_q.status[gpio_port_pkg::ST_IRQ0])
    else $error("Interrupt event lost.");

endmodule

// file: tb/pad_partner.sv
module pad_partner (
  input wire logic CLK_IN,
  input wire logic [7:0] DRV_IN,
  input wire logic [7:0] OE_IN,
  input wire logic [7:0] PULL_IN,
  input wire logic [7:0] EXT_EN_IN,
  input wire logic [7:0] EXT_VAL_IN,
  output logic [7:0] PAD_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_q = 1'b0;
  // ****************************************
  // Pad resolution.
  // ****************************************
  // A floating line wanders every cycle, so a stale level can never pass for a driven one.
  always @(posedge CLK_IN) begin
    flip_q <= ~flip_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (OE_IN[i]) begin
        PAD_OUT[i] = DRV_IN[i];
      end else if (EXT_EN_IN[i]) begin
        PAD_OUT[i] = EXT_VAL_IN[i];
      end else if (PULL_IN[i]) begin
        PAD_OUT[i] = 1'b1;
      end else begin
        PAD_OUT[i] = flip_q ^ i[0];
      end
    end
  end
endmodule

// file: tb/bidirectional_port_logic_bench.sv
module bidirectional_port_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic err; logic [31:0] d;} note_type;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_ev, wake, pdn, irq;
  logic [7:0] pad, pad_drv, pad_oe, pull;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] l, d, x, pv, p;
  logic [2:0] bi;
  note_type notes[$];
  note_type ne;
  int num_errors = 0;
  int checked = 0;
  int k, n;

  gpio_port dut_u (.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PAD_IN(pad),
    .PAD_OUT(pad_drv), .PAD_OE_OUT(pad_oe), .PULL_EN_OUT(pull), .TIMER_EVENT_OUT(timer_ev),
    .WAKE_REQ_OUT(wake), .POWERED_DOWN_OUT(pdn), .IRQ_OUT(irq));
  pad_partner partner_u (.CLK_IN(clk), .DRV_IN(pad_drv), .OE_IN(pad_oe), .PULL_IN(pull),
    .EXT_EN_IN(ext_en), .EXT_VAL_IN(ext_val), .PAD_OUT(pad));

  always #5 clk = ~clk;

  // ****************************************
  // Checking and bus tasks.
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      input logic [31:0] e, input logic err);
    notes.push_back('{w, err, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, e, 1'b0);
  endtask

  // Pads pass two synchroniser stages, so three edges always cover a change.
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      ne = notes.pop_front();
      chk({31'h0, pslverr}, {31'h0, ne.err});
      if (!ne.w) begin
        chk(prdata, ne.d);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    end_of_test();
  end

  // ****************************************
  // Scenarios.
  // ****************************************
  initial begin
    void'($urandom(74));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    chk({24'h0, pad_oe}, 32'h0);
    chk({24'h0, pull}, 32'h0);
    rd(gpio_port_pkg::OFS_DIR, 32'hFF);
    for (k = 0; k < 8; k++) begin
      l = 8'($urandom);
      d = 8'($urandom);
      x = 8'($urandom);
      ext_val <= x;
      wr(gpio_port_pkg::OFS_DATA, {24'h0, l});
      wr(gpio_port_pkg::OFS_DIR, {24'h0, d});
      settle();
      chk({24'h0, pad_oe}, {24'h0, ~d});
      chk({24'h0, pad_drv}, {24'h0, l});
      pv = (x & d) | (l & ~d);
      rd(gpio_port_pkg::OFS_DATA, {24'h0, pv});
      rd(gpio_port_pkg::OFS_INV_READ, {24'h0, ~pv});
      for (n = 0; n < 4; n++) begin
        bi = 3'($urandom_range(7, 0));
        wr(gpio_port_pkg::OFS_BITOP, {26'h0, 2'(n), 1'b0, bi});
        pv = (x & d) | (l & ~d);
        case (2'(n))
          gpio_port_pkg::BITOP_SET: pv[bi] = 1'b1;
          gpio_port_pkg::BITOP_CLR: pv[bi] = 1'b0;
          gpio_port_pkg::BITOP_INV: pv = ~pv;
          default: pv = l;
        endcase
        l = pv;
        @(posedge clk);
        chk({24'h0, pad_drv}, {24'h0, l});
        rd(gpio_port_pkg::OFS_DATA, {24'h0, (x & d) | (l & ~d)});
      end
    end
    ext_en <= 8'h00;
    p = 8'($urandom);
    wr(gpio_port_pkg::OFS_DIR, 32'hFF);
    wr(gpio_port_pkg::OFS_PULL, {24'h0, p});
    @(posedge clk);
    chk({24'h0, pull}, {24'h0, p});
    wr(gpio_port_pkg::OFS_PULL, 32'hFF);
    settle();
    rd(gpio_port_pkg::OFS_DATA, 32'hFF);
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    wr(gpio_port_pkg::OFS_MASK, 32'h1);
    settle();
    for (k = 0; k < 2; k++) begin
      for (n = 0; n < 4; n++) begin
        wr(gpio_port_pkg::OFS_TRIG, 32'(n << (2 * k)));
        wr(gpio_port_pkg::OFS_STATUS, 32'h7);
        ext_val[k] <= 1'b1;
        settle();
        rd(gpio_port_pkg::OFS_STATUS, 32'(n[0]) << k);
        chk({31'h0, irq}, {31'h0, k == 0 && n[0]});
        wr(gpio_port_pkg::OFS_STATUS, 32'h7);
        ext_val[k] <= 1'b0;
        settle();
        rd(gpio_port_pkg::OFS_STATUS, 32'(n[1]) << k);
      end
    end
    wr(gpio_port_pkg::OFS_TRIG, 32'h0);
    wr(gpio_port_pkg::OFS_STATUS, 32'h7);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    ext_val[2] <= 1'b1;
    settle();
    chk({31'h0, timer_ev}, 32'h1);
    ext_val[2] <= 1'b0;
    settle();
    chk({31'h0, timer_ev}, 32'h0);
    wr(gpio_port_pkg::OFS_WAKE, 32'h10);
    wr(gpio_port_pkg::OFS_PDOWN, 32'h1);
    @(posedge clk);
    chk({31'h0, pdn}, 32'h1);
    ext_val[3] <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, pdn}, 32'h1);
    ext_val[4] <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, wake}, 32'h1);
    chk({31'h0, pdn}, 32'h0);
    rd(gpio_port_pkg::OFS_STATUS, 32'h4);
    // With the clock enable low the block is frozen, so this write must not land.
    ce <= 1'b0;
    wr(gpio_port_pkg::OFS_MASK, 32'h6);
    ce <= 1'b1;
    rd(gpio_port_pkg::OFS_MASK, 32'h1);
    xfer(1'b0, 8'h28, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, 8'h28, 32'h5A, 32'h0, 1'b1);
    // Idle lines end as outputs, so nothing is left floating.
    wr(gpio_port_pkg::OFS_DIR, 32'h0);
    repeat (2) @(posedge clk);
    if (notes.size() != 0) begin
      num_errors++;
      $display("CHECK FAILED at %0t: transfers left unchecked", $time);
    end
    end_of_test();
  end
endmodule
